// ### design/twmr_top.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
module twmr_top
    import twmr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    twmr_core_s q;
    twmr_core_s d;
    logic [1:0] pins_s;
    logic       bus_scl;
    logic       bus_sda;
    logic       start_det;
    logic       stop_det;
    logic       busy;
    logic       scl_rise;
    logic       scl_fall;
    logic       wr;
    logic       tick;
    logic       chk;
    logic       gc_hit;
    logic       own_hit;
    logic [7:0] wd;

    // ****************************************************************
    // Pin synchronisers and bus monitor.
    // ****************************************************************
    twmr_sync #(.W(2)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({scl_i, sda_i}),
        .dout  (pins_s)
    );

    assign bus_scl = pins_s[1];
    assign bus_sda = pins_s[0];

    twmr_busmon u_mon (
        .clock     (clock),
        .nrst      (nrst),
        .scl_s     (bus_scl),
        .sda_s     (bus_sda),
        .start_det (start_det),
        .stop_det  (stop_det),
        .busy      (busy),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall)
    );

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        d       = q;
        wd      = avs_writedata[7:0];
        wr      = avs_write & q.ack & avs_byteenable[0];
        tick    = (q.cnt == 7'h00);
        chk     = (q.addr_ph | ~q.rd_mode) ? (q.bits != LAST_BIT) : (q.bits == LAST_BIT);
        own_hit = (q.sl_sh[7:1] == q.own[7:1]);
        gc_hit  = (q.sl_sh == GC_ADDR) & q.own[OB_GCE];
        d.ack   = (avs_read | avs_write) & ~q.ack;
        d.cnt   = tick ? 7'h00 : q.cnt - 7'h01;

        // Read data is captured in the cycle before the answer.
        if (avs_read & ~q.ack) begin
            case (avs_address)
                OFS_CTRL: d.rdata = {q.flag, q.ea, q.sta, q.sto, q.wc, q.en, 1'b0, q.ie};
                OFS_STAT: d.rdata = {q.status[7:3], 1'b0, q.presc};
                OFS_DATA: d.rdata = q.data;
                OFS_OWN:  d.rdata = q.own;
                default:  d.rdata = 8'h00;
            endcase
        end

        if (wr) begin
            case (avs_address)
                OFS_CTRL: begin
                    if (wd[CB_FLAG]) begin
                        d.flag = 1'b0;
                    end
                    d.ea  = wd[CB_EA];
                    d.sta = wd[CB_STA];
                    d.sto = wd[CB_STO];
                    d.en  = wd[CB_EN];
                    d.ie  = wd[CB_IE];
                end
                OFS_STAT: d.presc = wd[1:0];
                OFS_DATA: begin
                    if (q.flag) begin
                        d.data = wd;
                        d.wc   = 1'b0;
                    end else begin
                        d.wc = 1'b1;
                    end
                end
                OFS_OWN:  d.own = wd;
                default:  ;
            endcase
        end

        // ************************************************************
        // Address watcher for slave recognition.
        // ************************************************************
        if (start_det) begin
            d.sl_on  = 1'b1;
            d.sl_cnt = 4'h0;
        end else if (stop_det) begin
            d.sl_on = 1'b0;
        end else if (q.sl_on && q.sl_cnt == LAST_BIT) begin
            d.sl_on = 1'b0;
            if (!q.master && q.en && q.ea && (own_hit || gc_hit) &&
                (q.st == S_IDLE || q.st == S_WAIT_FREE)) begin
                d.st = S_SL_A;
            end
        end else if (q.sl_on && scl_rise) begin
            d.sl_sh  = {q.sl_sh[6:0], bus_sda};
            d.sl_cnt = q.sl_cnt + 4'h1;
        end

        // ************************************************************
        // Bus engine.
        // ************************************************************
        case (q.st)
            S_IDLE: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b0;
                if (q.en && q.sta && !q.flag && d.st == S_IDLE) begin
                    d.st  = S_WAIT_FREE;
                    d.arb = 1'b0;
                end
            end
            S_WAIT_FREE: begin
                if (!busy && d.st == S_WAIT_FREE) begin
                    d.st  = S_START_A;
                    d.cnt = HALF_LOAD;
                    d.rs  = 1'b0;
                end
            end
            S_RS_A: begin
                d.sda_oe = 1'b0;
                if (tick) begin
                    d.st     = S_START_A;
                    d.cnt    = HALF_LOAD;
                    d.rs     = 1'b1;
                    d.scl_oe = 1'b0;
                end
            end
            S_START_A: begin
                d.scl_oe = 1'b0;
                if (!bus_scl) begin
                    d.cnt = HALF_LOAD;
                end else if (tick) begin
                    d.sda_oe = 1'b1;
                    d.st     = S_START_B;
                    d.cnt    = HALF_LOAD;
                end
            end
            S_START_B: begin
                if (tick) begin
                    d.scl_oe = 1'b1;
                    d.master = 1'b1;
                    d.flag   = 1'b1;
                    d.status = q.rs ? SC_RSTART : SC_START;
                    d.st     = S_HOLD;
                end
            end
            S_HOLD: begin
                d.scl_oe = 1'b1;
                if (!q.flag) begin
                    d.cnt = HALF_LOAD;
                    if (q.sto) begin
                        d.st     = S_STOP_A;
                        d.sda_oe = 1'b1;
                    end else if (q.sta) begin
                        d.st = S_RS_A;
                    end else begin
                        d.bits = 4'h0;
                        d.st   = S_BIT_L;
                        if (q.status == SC_START || q.status == SC_RSTART) begin
                            d.tx      = {q.data, 1'b1};
                            d.addr_ph = 1'b1;
                            d.rd_mode = q.data[0];
                        end else if (q.rd_mode) begin
                            d.tx = {8'hFF, ~q.ea};
                        end else begin
                            d.tx = {q.data, 1'b1};
                        end
                    end
                end
            end
            S_BIT_L: begin
                d.scl_oe = 1'b1;
                d.sda_oe = ~q.tx[8];
                if (tick) begin
                    d.scl_oe = 1'b0;
                    d.st     = S_BIT_H;
                    d.cnt    = HALF_LOAD;
                end
            end
            S_BIT_H: begin
                if (!bus_scl) begin
                    d.cnt = HALF_LOAD;
                end else if (tick) begin
                    d.rx     = {q.rx[7:0], bus_sda};
                    d.tx     = {q.tx[7:0], 1'b1};
                    d.bits   = q.bits + 4'h1;
                    d.scl_oe = 1'b1;
                    if (q.tx[8] && !bus_sda && chk) begin
                        d.scl_oe = 1'b0;
                        d.sda_oe = 1'b0;
                        d.master = 1'b0;
                        d.arb    = 1'b1;
                        d.flag   = 1'b1;
                        d.status = SC_ARB;
                        d.st     = S_IDLE;
                    end else if (q.bits == LAST_BIT) begin
                        d.flag    = 1'b1;
                        d.st      = S_HOLD;
                        d.addr_ph = 1'b0;
                        if (q.addr_ph) begin
                            if (q.rd_mode) begin
                                d.status = bus_sda ? SC_MR_ANAK : SC_MR_AACK;
                            end else begin
                                d.status = bus_sda ? SC_MT_ANAK : SC_MT_AACK;
                            end
                        end else if (q.rd_mode) begin
                            d.data   = q.rx[7:0];
                            d.status = bus_sda ? SC_MR_DNAK : SC_MR_DACK;
                        end else begin
                            d.status = bus_sda ? SC_MT_DNAK : SC_MT_DACK;
                        end
                    end else begin
                        d.st  = S_BIT_L;
                        d.cnt = HALF_LOAD;
                    end
                end
            end
            S_STOP_A: begin
                d.sda_oe = 1'b1;
                if (tick) begin
                    d.scl_oe = 1'b0;
                    d.st     = S_STOP_B;
                    d.cnt    = HALF_LOAD;
                end
            end
            S_STOP_B: begin
                if (!bus_scl) begin
                    d.cnt = HALF_LOAD;
                end else if (tick) begin
                    d.sda_oe = 1'b0;
                    d.st     = S_STOP_C;
                    d.cnt    = HALF_LOAD;
                end
            end
            S_STOP_C: begin
                if (tick) begin
                    d.sto    = 1'b0;
                    d.master = 1'b0;
                    d.status = SC_NONE;
                    d.st     = S_IDLE;
                end
            end
            S_SL_A: begin
                if (scl_fall) begin
                    d.sda_oe = 1'b1;
                    d.st     = S_SL_B;
                end
            end
            S_SL_B: begin
                if (scl_fall) begin
                    d.scl_oe = 1'b1;
                    d.flag   = 1'b1;
                    d.arb    = 1'b0;
                    d.st     = S_SL_HOLD;
                    if (q.sl_sh == GC_ADDR) begin
                        d.status = q.arb ? SC_SR_GCA : SC_SR_GC;
                    end else if (q.sl_sh[0]) begin
                        d.status = q.arb ? SC_ST_OWNA : SC_ST_OWN;
                    end else begin
                        d.status = q.arb ? SC_SR_OWNA : SC_SR_OWN;
                    end
                end
            end
            S_SL_HOLD: begin
                if (!q.flag) begin
                    d.sda_oe = 1'b0;
                    d.status = SC_NONE;
                    d.st     = S_IDLE;
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase

        if (!q.en) begin
            d.st     = S_IDLE;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.master = 1'b0;
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            q        <= '0;
            q.st     <= S_IDLE;
            q.status <= SC_NONE;
            q.tx     <= 9'h1FF;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs. Pins are open drain: only the enables toggle.
    // ****************************************************************
    assign avs_readdata    = {24'h000000, q.rdata};
    assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    assign scl_o           = 1'b0;
    assign sda_o           = 1'b0;
    assign scl_oe          = q.scl_oe;
    assign sda_oe          = q.sda_oe;

endmodule
`default_nettype wire

// ### design/twmr_pkg.sv
package twmr_pkg;

    // ****************************************************************
    // Register map, byte addresses on the Avalon-MM slave.
    // ****************************************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_OWN  = 4'hC;

    // ****************************************************************
    // Field positions of the control register, and the general-call enable bit of the own-address register.
    // ****************************************************************
    localparam int CB_FLAG = 7;
    localparam int CB_EA   = 6;
    localparam int CB_STA  = 5;
    localparam int CB_STO  = 4;
    localparam int CB_WC   = 3;
    localparam int CB_EN   = 2;
    localparam int CB_IE   = 0;
    localparam int OB_GCE  = 0;

    // ****************************************************************
    // Status codes, and the general-call address.
    // ****************************************************************
    localparam logic [7:0] SC_START   = 8'h08;
    localparam logic [7:0] SC_RSTART  = 8'h10;
    localparam logic [7:0] SC_MT_AACK = 8'h18;
    localparam logic [7:0] SC_MT_ANAK = 8'h20;
    localparam logic [7:0] SC_MT_DACK = 8'h28;
    localparam logic [7:0] SC_MT_DNAK = 8'h30;
    localparam logic [7:0] SC_ARB     = 8'h38;
    localparam logic [7:0] SC_MR_AACK = 8'h40;
    localparam logic [7:0] SC_MR_ANAK = 8'h48;
    localparam logic [7:0] SC_MR_DACK = 8'h50;
    localparam logic [7:0] SC_MR_DNAK = 8'h58;
    localparam logic [7:0] SC_SR_OWN  = 8'h60;
    localparam logic [7:0] SC_SR_OWNA = 8'h68;
    localparam logic [7:0] SC_SR_GC   = 8'h70;
    localparam logic [7:0] SC_SR_GCA  = 8'h78;
    localparam logic [7:0] SC_ST_OWN  = 8'hA8;
    localparam logic [7:0] SC_ST_OWNA = 8'hB0;
    localparam logic [7:0] SC_NONE    = 8'hF8;
    localparam logic [7:0] GC_ADDR    = 8'h00;

    // ****************************************************************
    // Bus timing: half a bit period at the system clock rate.
    // ****************************************************************
    localparam int         CLK_NS    = 100;
    localparam int         HALF_NS   = 5000;
    localparam int         HALF_CYC  = (HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] HALF_LOAD = 7'(HALF_CYC - 1);
    localparam logic [3:0] LAST_BIT  = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE, S_WAIT_FREE, S_RS_A, S_START_A, S_START_B, S_HOLD, S_BIT_L,
        S_BIT_H, S_STOP_A, S_STOP_B, S_STOP_C, S_SL_A, S_SL_B, S_SL_HOLD
    } twmr_st_e;

    typedef struct packed {
        twmr_st_e   st;
        logic [6:0] cnt;
        logic [3:0] bits;
        logic [8:0] tx;
        logic [8:0] rx;
        logic       flag;
        logic       ea;
        logic       sta;
        logic       sto;
        logic       wc;
        logic       en;
        logic       ie;
        logic [7:0] status;
        logic [1:0] presc;
        logic [7:0] data;
        logic [7:0] own;
        logic       master;
        logic       rs;
        logic       rd_mode;
        logic       addr_ph;
        logic       arb;
        logic       scl_oe;
        logic       sda_oe;
        logic       sl_on;
        logic [3:0] sl_cnt;
        logic [7:0] sl_sh;
        logic       ack;
        logic [7:0] rdata;
    } twmr_core_s;

endpackage

// ### design/twmr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module twmr_sync #(
    parameter int W = 2
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } twmr_sync_s;

    twmr_sync_s q;
    twmr_sync_s d;

    // ****************************************************************
    // Two flops; the first is read only by the second.
    // ****************************************************************
    always_comb begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule
`default_nettype wire

// ### design/twmr_busmon.sv
`timescale 1ns/100ps
`default_nettype none
module twmr_busmon
    import twmr_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic scl_s,
    input  wire logic sda_s,
    output logic      start_det,
    output logic      stop_det,
    output logic      busy,
    output logic      scl_rise,
    output logic      scl_fall
);

    typedef struct packed {
        logic scl;
        logic sda;
        logic busy;
    } twmr_mon_s;

    twmr_mon_s q;
    twmr_mon_s d;

    // ****************************************************************
    // START, STOP and clock edges from the synchronised lines.
    // ****************************************************************
    always_comb begin
        start_det = q.scl & scl_s & q.sda & ~sda_s;
        stop_det  = q.scl & scl_s & ~q.sda & sda_s;
        scl_rise  = ~q.scl & scl_s;
        scl_fall  = q.scl & ~scl_s;
        d.scl     = scl_s;
        d.sda     = sda_s;
        d.busy    = q.busy;
        if (start_det) begin
            d.busy = 1'b1;
        end else if (stop_det) begin
            d.busy = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            q <= '{scl: 1'b1, sda: 1'b1, busy: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign busy = q.busy;

endmodule
`default_nettype wire

// ### testbench/twmr_properties.sv
`timescale 1ns/100ps
`default_nettype none
module twmr_properties
    import twmr_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_o,
    input wire logic        sda_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request taken without a wait cycle");
    AST_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    AST_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_STAT: assert property (avs_read && !avs_waitrequest && avs_address == OFS_STAT |->
        avs_readdata[2] == 1'b0)
        else $error("status bit 2 not zero");
    AST_DRAIN: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    AST_START: assert property ($rose(sda_oe) && scl_i && !scl_oe |-> !scl_oe [*8])
        else $error("start hold too short");
    AST_LOW: assert property ($rose(scl_oe) |-> scl_oe [*8])
        else $error("clock low half too short");
    AST_HIGH: assert property ($fell(scl_oe) |-> !scl_oe [*8])
        else $error("clock high half too short");
    AST_SDA_MOVE: assert property ($changed(sda_oe) && !scl_oe |-> !$past(scl_oe, 8))
        else $error("data line moved with clock released too briefly");
endmodule
bind twmr_top twmr_properties u_props (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ### testbench/twmr_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module twmr_slave_model #(
    parameter logic [6:0] ADDR  = 7'h2A,
    parameter logic [7:0] FIRST = 8'hA5
) (
    input  wire logic clock,
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_oe
);
    logic       sp = 1'b1;
    logic       dp = 1'b1;
    logic [1:0] ph = 2'h3;
    logic [3:0] b = 4'h0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = FIRST;
    logic [3:0] nb;
    assign nb = (b == 4'h8) ? 4'h0 : b + 4'h1;
    initial sda_oe = 1'b0;
    always @(posedge clock) begin
        sp <= scl;
        dp <= sda;
        if (sp && scl && dp && !sda) begin
            ph <= 2'h0;
            b <= 4'hF;
            sda_oe <= 1'b0;
        end else if (scl && !dp && sda) begin
            ph <= 2'h3;
            sda_oe <= 1'b0;
        end else if (!sp && scl) begin
            if (ph == 2'h0 && b < 4'h8) sh <= {sh[6:0], sda};
            if (ph == 2'h1 && b == 4'h8) begin
                if (sda) ph <= 2'h3;
                else tx <= tx + 8'h3C;
            end
        end else if (sp && !scl) begin
            b <= nb;
            if (ph == 2'h0 && nb == 4'h8) sda_oe <= (sh == {ADDR, 1'b1});
            else if (ph == 2'h0 && b == 4'h8) begin
                ph <= sda_oe ? 2'h1 : 2'h3;
                sda_oe <= sda_oe && !tx[7];
            end else sda_oe <= ph == 2'h1 && nb < 4'h8 && !tx[3'(4'h7 - nb)];
        end
    end
endmodule
`default_nettype wire

// ### testbench/twmr_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module twmr_top_tb
    import twmr_pkg::*;
;
    localparam logic [6:0] SADDR = 7'h2A;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, scl_oe, sda_oe, m_oe;
    // A second master that holds the data line low to win arbitration.
    logic        x_oe = 1'b0;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | m_oe | x_oe);
    int          errors = 0;
    int          n_checks = 0;
    logic [7:0]  q;
    initial begin
        forever #50 clock = ~clock;
    end
    twmr_top uut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe));
    twmr_slave_model #(.ADDR(SADDR)) peer (.clock(clock), .scl(scl), .sda(sda), .sda_oe(m_oe));
    // ****************************************************************
    // Bus and compare tasks.
    // ****************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input string what, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(what, exp, q);
    endtask
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        bus(1'b1, OFS_CTRL, c);
        q = 8'h00;
        while (q[7] !== 1'b1) bus(1'b0, OFS_CTRL, 8'h00);
        chk("scl held", 8'h00, {7'h0, scl});
        bus(1'b0, OFS_STAT, 8'h00);
        chk("status", st, q & 8'hF8);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_regs();
        rd(OFS_CTRL, "ctrl", 8'h00);
        rd(OFS_STAT, "status", 8'hF8);
        rd(4'h2, "unmapped", 8'h00);
        bus(1'b1, OFS_OWN, 8'h33);
        rd(OFS_OWN, "own", 8'h33);
        bus(1'b1, OFS_DATA, 8'h5A);
        rd(OFS_CTRL, "collision", 8'h08);
    endtask
    task automatic t_read();
        step(8'hA4, SC_START);
        bus(1'b1, OFS_DATA, {SADDR, 1'b1});
        step(8'h84, SC_MR_AACK);
        step(8'hC4, SC_MR_DACK);
        rd(OFS_DATA, "byte", 8'hA5);
        step(8'h84, SC_MR_DNAK);
        rd(OFS_DATA, "byte", 8'hE1);
    endtask
    task automatic t_restart();
        step(8'hA4, SC_RSTART);
        bus(1'b1, OFS_DATA, {7'h11, 1'b1});
        step(8'h84, SC_MR_ANAK);
        step(8'hB4, SC_START);
        rd(OFS_DATA, "rs data", 8'h23);
        bus(1'b1, OFS_DATA, {SADDR, 1'b1});
        step(8'h84, SC_MR_AACK);
        step(8'h84, SC_MR_DNAK);
        rd(OFS_DATA, "byte", 8'hE1);
    endtask
    task automatic t_stop();
        bus(1'b1, OFS_CTRL, 8'h94);
        q = 8'h10;
        while (q[4] !== 1'b0) bus(1'b0, OFS_CTRL, 8'h00);
        rd(OFS_STAT, "idle", SC_NONE);
        repeat (60) @(posedge clock);
        chk("lines", 8'h03, {6'h0, scl, sda});
    endtask
    task automatic t_arb();
        step(8'hA4, SC_START);
        bus(1'b1, OFS_DATA, 8'hFF);
        x_oe <= 1'b1;
        bus(1'b1, OFS_CTRL, 8'h84);
        q = 8'h00;
        while (q[7] !== 1'b1) bus(1'b0, OFS_CTRL, 8'h00);
        rd(OFS_STAT, "arb status", SC_ARB);
        chk("arb lines", 8'h02, {6'h0, scl, sda});
        bus(1'b1, OFS_CTRL, 8'hA4);
        repeat (200) @(posedge clock);
        rd(OFS_CTRL, "start held", 8'h24);
        x_oe <= 1'b0;
        step(8'hA4, SC_START);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_read();
        t_restart();
        t_stop();
        t_arb();
        t_stop();
        tally_and_finish();
    end
endmodule
`default_nettype wire
